//--- rtl/local_remote_source_select.sv
// Local/remote mode and frequency/command source selection with its register slave.
//
// Functional notes
// - User value readback shows the value only while user maximum is nonzero.
// - User value applies only when remote frequency source is keypad or serial.
// - Nonzero user maximum makes the keypad show the configured display unit.
// - Display unit configuration code 33 selects percent.
// - Switch mode 1 stops the drive on every local/remote switchover.
// - Switch mode 2 keeps running on remote settings after a switchover.
// - Switch mode 3 keeps running on local settings after a switchover.
// - Switch mode 4 uses the settings of whichever mode was entered.
// - Switch mode register resets to 4.
// - Sources come from the local pair when use_local is set, from the remote pair otherwise.
// - Switch mode 0 ignores the function-56 terminal input.
// - Nonzero switch mode shows the local or remote indicator.
// - Auto key selects remote, hand key selects local.
// - Nonzero switch mode disables keys; the function-56 terminal then selects the mode.
// - Local source codes: 0,1,2,3,4,7,9 are keypad..PID.
// - Local frequency source selects the reference in local mode.
// - Hand-off-auto acts only with terminal 41 or 56 mapped or keypad fitted.
// - Nonzero user maximum corresponds to the maximum output frequency.
// - Remote frequency source selects the reference in remote mode.
// - The drive comes up in remote mode.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module local_remote_source_select (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic key_hand,
  input wire logic key_auto,
  input wire logic terminal_local_select,
  input wire logic keypad_fitted,
  input wire logic [15:0] output_frequency,
  output logic [15:0] active_freq_source,
  output logic [15:0] active_cmd_source,
  output logic local_indicator,
  output logic remote_indicator,
  output logic drive_stop,
  output logic unit_valid,
  output logic [11:0] display_unit,
  output logic percent_unit
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] remote_freq;
    logic [15:0] remote_cmd;
    logic [15:0] disp_cfg;
    logic [15:0] user_max;
    logic [15:0] switch_mode;
    logic [15:0] local_freq;
    logic [15:0] local_cmd;
    logic [15:0] max_freq;
    logic [1:0] input_map;
    logic mode_local;
    logic use_local;
    logic stop_pulse;
    logic [15:0] user_value;
    logic div_pending;
    logic [15:0] act_freq;
    logic [15:0] act_cmd;
    logic local_ind;
    logic remote_ind;
    logic unit_ok;
    logic [11:0] unit_code;
    logic percent;
    logic [15:0] readback;
  } sel_state_t;

  sel_state_t st;
  sel_state_t next_st;
  logic [3:0] pins;
  logic hand_s;
  logic auto_s;
  logic sel_s;
  logic fitted_s;
  logic hand_off_auto_on;
  logic req_local;
  logic req_remote;
  logic user_ok;
  logic [7:0] idx;
  logic bus_req;
  scale_if sif ();

  function automatic logic valid_local_src(input logic [15:0] code);
    valid_local_src = (code == lr_pkg::SRC_KEYPAD) || (code == lr_pkg::SRC_SERIAL) ||
      (code == lr_pkg::SRC_ANALOG) || (code == lr_pkg::SRC_UPDOWN) ||
      (code == lr_pkg::SRC_PULSE) || (code == lr_pkg::SRC_DIAL) || (code == lr_pkg::SRC_PID);
  endfunction : valid_local_src

  ////////////////////////////////////////////////////////////////////////////
  pin_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({key_hand, key_auto, terminal_local_select, keypad_fitted}),
    .pin_out(pins)
  );

  user_scale_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sif(sif.divider)
  );

  assign hand_s = pins[3];
  assign auto_s = pins[2];
  assign sel_s = pins[1];
  assign fitted_s = pins[0];
  assign idx = avs_address[9:2];
  assign bus_req = avs_read || avs_write;

  assign hand_off_auto_on = st.input_map[lr_pkg::MAP_FN41] || st.input_map[lr_pkg::MAP_FN56] || fitted_s;

  // Keys act only in mode 0, where the terminal is ignored; in a nonzero mode the keys are not even looked at.
  always_comb begin
    req_local = 1'b0;
    req_remote = 1'b0;
    if (hand_off_auto_on) begin
      if (st.switch_mode == lr_pkg::MODE_HAND_OFF_AUTO) begin
        req_local = hand_s && !auto_s;
        req_remote = auto_s && !hand_s;
      end else if (st.input_map[lr_pkg::MAP_FN56]) begin
        req_local = sel_s;
        req_remote = !sel_s;
      end
    end
  end

  assign user_ok = (st.remote_freq == lr_pkg::SRC_KEYPAD) || (st.remote_freq == lr_pkg::SRC_SERIAL);

  assign sif.start = st.div_pending;
  assign sif.dividend = 32'(output_frequency) * 32'(st.user_max);
  assign sif.divisor = st.max_freq;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.stop_pulse = 1'b0;
    // Bus slave: one wait cycle, then the access completes with waitrequest low.
    if (!st.waitreq) begin
      next_st.waitreq = 1'b1;
    end else if (bus_req) begin
      next_st.waitreq = 1'b0;
      case (idx)
        lr_pkg::IDX_REMOTE_FREQ: next_st.rdata = {16'h0000, st.remote_freq};
        lr_pkg::IDX_REMOTE_CMD: next_st.rdata = {16'h0000, st.remote_cmd};
        lr_pkg::IDX_DISP_CFG: next_st.rdata = {16'h0000, st.disp_cfg};
        lr_pkg::IDX_USER_MAX: next_st.rdata = {16'h0000, st.user_max};
        lr_pkg::IDX_USER_READBACK: next_st.rdata = {16'h0000, st.readback};
        lr_pkg::IDX_SWITCH_MODE: next_st.rdata = {16'h0000, st.switch_mode};
        lr_pkg::IDX_LOCAL_FREQ: next_st.rdata = {16'h0000, st.local_freq};
        lr_pkg::IDX_LOCAL_CMD: next_st.rdata = {16'h0000, st.local_cmd};
        lr_pkg::IDX_MAX_FREQ: next_st.rdata = {16'h0000, st.max_freq};
        lr_pkg::IDX_STATUS: next_st.rdata = {27'h000_0000, st.percent, st.unit_ok, hand_off_auto_on,
          st.use_local, st.mode_local};
        lr_pkg::IDX_INPUT_MAP: next_st.rdata = {30'h0000_0000, st.input_map};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !st.waitreq) begin
      case (idx)
        lr_pkg::IDX_REMOTE_FREQ: next_st.remote_freq = avs_writedata[15:0];
        lr_pkg::IDX_REMOTE_CMD: next_st.remote_cmd = avs_writedata[15:0];
        lr_pkg::IDX_DISP_CFG: next_st.disp_cfg = avs_writedata[15:0];
        lr_pkg::IDX_USER_MAX: next_st.user_max = avs_writedata[15:0];
        lr_pkg::IDX_SWITCH_MODE: begin
          if (avs_writedata[15:0] <= lr_pkg::MODE_MAINTAIN) begin
            next_st.switch_mode = avs_writedata[15:0];
          end
        end
        lr_pkg::IDX_LOCAL_FREQ: begin
          if (valid_local_src(avs_writedata[15:0])) begin
            next_st.local_freq = avs_writedata[15:0];
          end
        end
        lr_pkg::IDX_LOCAL_CMD: next_st.local_cmd = avs_writedata[15:0];
        lr_pkg::IDX_MAX_FREQ: next_st.max_freq = avs_writedata[15:0];
        lr_pkg::IDX_INPUT_MAP: next_st.input_map = avs_writedata[1:0];
        default: next_st.input_map = st.input_map;
      endcase
    end

    // Mode switchover and the choice of which pair of settings stays in force.
    if ((req_local && !st.mode_local) || (req_remote && st.mode_local)) begin
      next_st.mode_local = req_local;
      case (st.switch_mode)
        lr_pkg::MODE_STOP: begin
          next_st.stop_pulse = 1'b1;
          next_st.use_local = req_local;
        end
        lr_pkg::MODE_KEEP_REMOTE: next_st.use_local = 1'b0;
        lr_pkg::MODE_KEEP_LOCAL: next_st.use_local = 1'b1;
        default: next_st.use_local = req_local;
      endcase
    end

    next_st.act_freq = st.use_local ? st.local_freq : st.remote_freq;
    next_st.act_cmd = st.use_local ? st.local_cmd : st.remote_cmd;

    next_st.local_ind = (st.switch_mode != lr_pkg::MODE_HAND_OFF_AUTO) && st.mode_local;
    next_st.remote_ind = (st.switch_mode != lr_pkg::MODE_HAND_OFF_AUTO) && !st.mode_local;

    next_st.unit_ok = st.user_max != 16'h0000;
    next_st.unit_code = st.disp_cfg[15:lr_pkg::UNIT_LSB];
    next_st.percent = (st.user_max != 16'h0000) &&
      (st.disp_cfg[15:lr_pkg::UNIT_LSB] == lr_pkg::UNIT_PERCENT[15:lr_pkg::UNIT_LSB]);

    // The divider is rerun continuously so the value tracks the output frequency.
    next_st.div_pending = 1'b0;
    if (sif.done) begin
      next_st.user_value = sif.quotient;
      next_st.div_pending = 1'b1;
    end else if (!st.div_pending && st.user_value == 16'h0000 && st.readback == 16'h0000) begin
      next_st.div_pending = 1'b1;
    end
    next_st.readback = ((st.user_max != 16'h0000) && user_ok) ? st.user_value : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.switch_mode <= lr_pkg::RST_SWITCH_MODE;
      st.local_freq <= lr_pkg::RST_ZERO;
      st.max_freq <= lr_pkg::RST_MAX_FREQ;
      st.mode_local <= 1'b0;
      st.use_local <= 1'b0;
      st.div_pending <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign active_freq_source = st.act_freq;
  assign active_cmd_source = st.act_cmd;
  assign local_indicator = st.local_ind;
  assign remote_indicator = st.remote_ind;
  assign drive_stop = st.stop_pulse;
  assign unit_valid = st.unit_ok;
  assign display_unit = st.unit_code;
  assign percent_unit = st.percent;

  ////////////////////////////////////////////////////////////////////////////
  // local codes legal
  a_local_src_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    valid_local_src(st.local_freq)) else $error("local frequency source holds an unlisted code");
  a_bad_code_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (avs_write && !st.waitreq && idx == lr_pkg::IDX_LOCAL_FREQ && !valid_local_src(avs_writedata[15:0]))
    |=> $stable(st.local_freq)) else $error("unlisted local source code was stored");
  a_readback_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.user_max == 16'h0000) ##1 (st.user_max == 16'h0000) |-> st.readback == 16'h0000)
    else $error("readback nonzero while user maximum is zero");
  a_readback_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.readback != 16'h0000) |-> $past(user_ok)) else $error("readback shown for a wrong source");
  a_unit_shown: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.unit_ok == ($past(st.user_max) != 16'h0000)) else $error("unit display does not follow maximum");
  a_percent_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.disp_cfg == lr_pkg::UNIT_PERCENT && st.user_max != 16'h0000) |=> st.percent)
    else $error("percent unit not selected");
  a_stop_switch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($changed(st.mode_local) && $past(st.switch_mode) == lr_pkg::MODE_STOP) |-> st.stop_pulse ##1 !st.stop_pulse)
    else $error("no single stop pulse on switchover");
  a_keep_remote: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($changed(st.mode_local) && $past(st.switch_mode) == lr_pkg::MODE_KEEP_REMOTE) |-> !st.use_local)
    else $error("remote settings not kept");
  a_keep_local: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($changed(st.mode_local) && $past(st.switch_mode) == lr_pkg::MODE_KEEP_LOCAL) |-> st.use_local)
    else $error("local settings not kept");
  a_follow_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($changed(st.mode_local) && $past(st.switch_mode) == lr_pkg::MODE_MAINTAIN) |-> st.use_local == st.mode_local)
    else $error("maintain mode does not follow the new mode");
  a_pair_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.use_local |=> st.act_freq == $past(st.local_freq)) else $error("local pair not used");
  a_key_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.switch_mode != lr_pkg::MODE_HAND_OFF_AUTO && !st.input_map[lr_pkg::MAP_FN56]) |=> $stable(st.mode_local))
    else $error("keys changed mode while disabled");
  c_go_local: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(st.mode_local));
  c_stop_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n) st.stop_pulse);
  c_readback: cover property (@(posedge sys_clk) disable iff (!rst_n) st.readback != 16'h0000);
endmodule : local_remote_source_select

//--- rtl/lr_pkg.sv
// Constants and register map for the local/remote source selection block.
package lr_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_REMOTE_FREQ = 8'h14;
  localparam logic [7:0] IDX_REMOTE_CMD = 8'h15;
  localparam logic [7:0] IDX_DISP_CFG = 8'h19;
  localparam logic [7:0] IDX_USER_MAX = 8'h1a;
  localparam logic [7:0] IDX_USER_READBACK = 8'h1b;
  localparam logic [7:0] IDX_SWITCH_MODE = 8'h1d;
  localparam logic [7:0] IDX_LOCAL_FREQ = 8'h1e;
  localparam logic [7:0] IDX_LOCAL_CMD = 8'h1f;
  localparam logic [7:0] IDX_MAX_FREQ = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_INPUT_MAP = 8'h42;
  // Reset values.
  localparam logic [15:0] RST_SWITCH_MODE = 16'h0004;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
  // Local/remote switchover modes.
  localparam logic [15:0] MODE_HAND_OFF_AUTO = 16'h0000;
  localparam logic [15:0] MODE_STOP = 16'h0001;
  localparam logic [15:0] MODE_KEEP_REMOTE = 16'h0002;
  localparam logic [15:0] MODE_KEEP_LOCAL = 16'h0003;
  localparam logic [15:0] MODE_MAINTAIN = 16'h0004;
  // Master frequency source codes.
  localparam logic [15:0] SRC_KEYPAD = 16'h0000;
  localparam logic [15:0] SRC_SERIAL = 16'h0001;
  localparam logic [15:0] SRC_ANALOG = 16'h0002;
  localparam logic [15:0] SRC_UPDOWN = 16'h0003;
  localparam logic [15:0] SRC_PULSE = 16'h0004;
  localparam logic [15:0] SRC_DIAL = 16'h0007;
  localparam logic [15:0] SRC_PID = 16'h0009;
  // Display unit field and the percent code.
  localparam int UNIT_LSB = 4;
  localparam logic [15:0] UNIT_PERCENT = 16'h0021;
  // Field positions in the status and input map registers.
  localparam int ST_LOCAL = 0;
  localparam int ST_USE_LOCAL = 1;
  localparam int ST_HAND_OFF_AUTO = 2;
  localparam int ST_UNIT_VALID = 3;
  localparam int ST_PERCENT = 4;
  localparam int MAP_FN41 = 0;
  localparam int MAP_FN56 = 1;
  // Serial divider length in steps.
  localparam logic [5:0] DIV_STEPS = 6'h20;
endpackage : lr_pkg

//--- rtl/scale_if.sv
// Request and answer signals between the selector and its scaling divider.
`timescale 1ns/1ps
interface scale_if;
  logic start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic [15:0] quotient;
  modport requester (output start, output dividend, output divisor, input done, input quotient);
  modport divider (input start, input dividend, input divisor, output done, output quotient);
endinterface : scale_if

//--- rtl/pin_sync.sv
// Two-stage synchroniser for the keypad and terminal inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;
  always_comb begin
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign pin_out = st.s2;
endmodule : pin_sync

//--- rtl/user_scale_div.sv
// Serial restoring divider that scales the frequency into the user-defined value.
`timescale 1ns/1ps
module user_scale_div (
  input wire logic sys_clk,
  input wire logic rst_n,
  scale_if.divider sif
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [16:0] partial;
    logic [31:0] quo;
    logic [15:0] div;
  } div_state_t;
  div_state_t st;
  div_state_t next_st;
  logic [16:0] trial;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.partial[15:0], st.quo[31]};
    if (!st.busy) begin
      if (sif.start) begin
        next_st.busy = 1'b1;
        next_st.cnt = lr_pkg::DIV_STEPS;
        next_st.partial = '0;
        next_st.quo = sif.dividend;
        next_st.div = sif.divisor;
      end
    end else begin
      if (trial >= {1'b0, st.div}) begin
        next_st.partial = trial - {1'b0, st.div};
        next_st.quo = {st.quo[30:0], 1'b1};
      end else begin
        next_st.partial = trial;
        next_st.quo = {st.quo[30:0], 1'b0};
      end
      next_st.cnt = st.cnt - 6'h01;
      if (st.cnt == 6'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // A quotient above the 16-bit range saturates rather than wrapping.
  assign sif.done = st.done;
  assign sif.quotient = (st.quo[31:16] != 16'h0000) ? 16'hffff : st.quo[15:0];
endmodule : user_scale_div

//--- verification/lr_partner.sv
// Behavioural model of the keypad keys, the terminal input and the frequency feedback.
`timescale 1ns/1ps
module lr_partner (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic want_hand,
  input wire logic want_auto,
  input wire logic want_local,
  input wire logic want_fitted,
  input wire logic [15:0] want_freq,
  output logic key_hand,
  output logic key_auto,
  output logic terminal_local_select,
  output logic keypad_fitted,
  output logic [15:0] output_frequency
);
  // The panel levels move one edge after they are asked for, so the bench never sees a same-edge change.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_hand <= 1'b0;
      key_auto <= 1'b0;
      terminal_local_select <= 1'b0;
      keypad_fitted <= 1'b0;
      output_frequency <= 16'h0000;
    end else begin
      key_hand <= want_hand;
      key_auto <= want_auto;
      terminal_local_select <= want_local;
      keypad_fitted <= want_fitted;
      output_frequency <= want_freq;
    end
  end
endmodule : lr_partner

//--- verification/tb_local_remote_source_select.sv
// Self-checking testbench for the local/remote source selection block.
`timescale 1ns/1ps
module tb_local_remote_source_select;
  localparam logic [31:0] LOCAL_F = 32'h0000_0003;
  localparam logic [31:0] REMOTE_F = 32'h0000_0002;
  localparam logic [31:0] LOCAL_C = 32'h0000_0001;
  localparam logic [31:0] REMOTE_C = 32'h0000_0002;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic want_hand, want_auto, want_local, want_fitted;
  logic [15:0] want_freq, output_frequency, active_freq_source, active_cmd_source;
  logic key_hand, key_auto, terminal_local_select, keypad_fitted;
  logic local_indicator, remote_indicator, drive_stop, unit_valid, percent_unit;
  logic [11:0] display_unit;
  int num_errors = 0;
  int num_checks = 0;
  int stop_count = 0;
  int seed = 32'h0000_5a07;
  logic [31:0] exp_q[$];
  ////////////////////////////////////////////////////////////////////////////////
  lr_partner u_lr_partner (.sys_clk(sys_clk), .rst_n(rst_n), .want_hand(want_hand), .want_auto(want_auto),
    .want_local(want_local), .want_fitted(want_fitted), .want_freq(want_freq), .key_hand(key_hand),
    .key_auto(key_auto), .terminal_local_select(terminal_local_select), .keypad_fitted(keypad_fitted),
    .output_frequency(output_frequency));
  local_remote_source_select u_local_remote_source_select (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .key_hand(key_hand), .key_auto(key_auto),
    .terminal_local_select(terminal_local_select), .keypad_fitted(keypad_fitted),
    .output_frequency(output_frequency),
    .active_freq_source(active_freq_source), .active_cmd_source(active_cmd_source),
    .local_indicator(local_indicator), .remote_indicator(remote_indicator), .drive_stop(drive_stop),
    .unit_valid(unit_valid), .display_unit(display_unit), .percent_unit(percent_unit));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // The request stays up until waitrequest is sampled low, for at most 100 edges before an error.
  task automatic bus_cycle(input logic rd, input logic [7:0] idx, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= data;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      $display("Error waitrequest never fell at index %h", idx);
      report_and_stop();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_cycle
  task automatic wr(input logic [7:0] idx, input logic [31:0] data);
    bus_cycle(1'b0, idx, data);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus_cycle(1'b1, idx, 32'h0000_0000);
  endtask : rd
  // Panel levels pass the partner flop, two sync flops and the mode logic, so eight edges is ample.
  task automatic pins(input logic h, input logic a, input logic l, input logic f);
    @(posedge sys_clk);
    want_hand <= h;
    want_auto <= a;
    want_local <= l;
    want_fitted <= f;
    repeat (8) @(posedge sys_clk);
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("Error readdata expected none seen %h", avs_readdata);
      end else begin
        check("readdata", avs_readdata, exp_q.pop_front());
      end
    end
    if (drive_stop === 1'b1) begin
      stop_count++;
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] last;
    logic [15:0] f;
    int n0;
    rst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    {want_hand, want_auto, want_local, want_fitted} = 4'h0;
    want_freq = 16'h0000;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(lr_pkg::IDX_SWITCH_MODE, 32'h0000_0004);
    rd(lr_pkg::IDX_USER_READBACK, 32'h0000_0000);
    check("remote_indicator", 32'(remote_indicator), 32'h0000_0001);
    last = 32'h0000_0000;
    for (int c = 0; c <= 10; c++) begin
      wr(lr_pkg::IDX_LOCAL_FREQ, 32'(c));
      if (c inside {0, 1, 2, 3, 4, 7, 9}) last = 32'(c);
      rd(lr_pkg::IDX_LOCAL_FREQ, last);
    end
    wr(lr_pkg::IDX_USER_READBACK, 32'h0000_1234);
    rd(lr_pkg::IDX_USER_READBACK, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    $display("test registers done");
    // Display setup goes first so the unit is right the moment the maximum turns nonzero.
    wr(lr_pkg::IDX_REMOTE_FREQ, 32'h0000_0000);
    wr(lr_pkg::IDX_DISP_CFG, 32'h0000_0021);
    f = 16'($unsigned($random(seed)) % 6000);
    @(posedge sys_clk);
    want_freq <= f;
    wr(lr_pkg::IDX_USER_MAX, 32'h0000_03e8);
    repeat (120) @(posedge sys_clk);
    rd(lr_pkg::IDX_USER_READBACK, 32'(f) * 32'h0000_03e8 / 32'h0000_1770);
    check("unit_valid", 32'(unit_valid), 32'h0000_0001);
    check("percent_unit", 32'(percent_unit), 32'h0000_0001);
    check("display_unit", 32'(display_unit), 32'h0000_0002);
    wr(lr_pkg::IDX_REMOTE_FREQ, REMOTE_F);
    repeat (120) @(posedge sys_clk);
    rd(lr_pkg::IDX_USER_READBACK, 32'h0000_0000);
    wr(lr_pkg::IDX_DISP_CFG, 32'h0000_0131);
    repeat (4) @(posedge sys_clk);
    check("percent_unit", 32'(percent_unit), 32'h0000_0000);
    check("display_unit", 32'(display_unit), 32'h0000_0013);
    wr(lr_pkg::IDX_USER_MAX, 32'h0000_0000);
    repeat (120) @(posedge sys_clk);
    check("unit_valid", 32'(unit_valid), 32'h0000_0000);
    rd(lr_pkg::IDX_USER_READBACK, 32'h0000_0000);
    $display("test user value done");
    wr(lr_pkg::IDX_LOCAL_FREQ, LOCAL_F);
    wr(lr_pkg::IDX_LOCAL_CMD, LOCAL_C);
    wr(lr_pkg::IDX_REMOTE_CMD, REMOTE_C);
    wr(lr_pkg::IDX_INPUT_MAP, 32'h0000_0002);
    for (int m = 1; m <= 4; m++) begin
      n0 = stop_count;
      wr(lr_pkg::IDX_SWITCH_MODE, 32'(m));
      pins(1'b0, 1'b0, 1'b1, 1'b0);
      check("local_indicator", 32'(local_indicator), 32'h0000_0001);
      check("active_freq", 32'(active_freq_source), (m == 2) ? REMOTE_F : LOCAL_F);
      check("active_cmd", 32'(active_cmd_source), (m == 2) ? REMOTE_C : LOCAL_C);
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      check("remote_indicator", 32'(remote_indicator), 32'h0000_0001);
      check("active_freq", 32'(active_freq_source), (m == 3) ? LOCAL_F : REMOTE_F);
      check("active_cmd", 32'(active_cmd_source), (m == 3) ? LOCAL_C : REMOTE_C);
      check("stop_pulses", 32'(stop_count - n0), (m == 1) ? 32'h0000_0002 : 32'h0000_0000);
    end
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    check("active_freq", 32'(active_freq_source), REMOTE_F);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test switchover modes done");
    wr(lr_pkg::IDX_SWITCH_MODE, 32'h0000_0000);
    wr(lr_pkg::IDX_INPUT_MAP, 32'h0000_0000);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    check("active_freq", 32'(active_freq_source), REMOTE_F);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    check("active_freq", 32'(active_freq_source), LOCAL_F);
    check("indicators", {30'h0, local_indicator, remote_indicator}, 32'h0000_0000);
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    check("active_freq", 32'(active_freq_source), REMOTE_F);
    wr(lr_pkg::IDX_INPUT_MAP, 32'h0000_0002);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    check("active_freq", 32'(active_freq_source), REMOTE_F);
    $display("test hand off auto done");
    repeat (4) @(posedge sys_clk);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("Error pending_reads expected 0 seen %0d", exp_q.size());
    end
    report_and_stop();
  end
endmodule : tb_local_remote_source_select
